// *** logic/hrs_pkg.sv ***
// Purpose: Shared constants and types for the hub reset sequencer
// Assumes: 125 MHz ref_clk
// Notes: Long counts are parameters of the top module
package hrs_pkg;

  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CLK_KHZ = 125000;

  // Times in their printed units
  localparam int unsigned RECOVERY_US = 500;
  localparam int unsigned INACTIVE_NS = 1500;
  localparam int unsigned ATTACH_MS = 100;
  localparam int unsigned EEPROM_MAX_US = 99500;
  localparam int unsigned SMBUS_MAX_US = 99500;
  localparam int unsigned REQUEST_MS = 5;

  // Derived cycle counts
  localparam int unsigned RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
  localparam int unsigned INACTIVE_CYC = (INACTIVE_NS * CLK_MHZ) / 1000;
  localparam int unsigned ATTACH_CYC = ATTACH_MS * CLK_KHZ;
  localparam int unsigned EEPROM_MAX_CYC = EEPROM_MAX_US * CLK_MHZ;
  localparam int unsigned SMBUS_MAX_CYC = SMBUS_MAX_US * CLK_MHZ;
  localparam int unsigned REQUEST_CYC = REQUEST_MS * CLK_KHZ;

  localparam int unsigned PORTS = 4;
  localparam logic [6:0] ADDR_RESET = 7'h00;

  // Configuration source select
  typedef enum logic [1:0] {
    HRS_CFG_STRAP = 2'h0,
    HRS_CFG_EEPROM = 2'h1,
    HRS_CFG_SMBUS = 2'h2,
    HRS_CFG_DEFAULT = 2'h3
  } hrs_cfg_t;

  typedef enum {
    HRS_S_RECOVER,
    HRS_S_LOAD,
    HRS_S_APPLY,
    HRS_S_RUN
  } hrs_state_t;

  // Straps caught after reset release
  typedef struct packed {
    logic power_enable_polarity_strap;
    logic led_strap_amber;
    logic led_strap_green;
  } hrs_strap_t;

  // Upstream host request handshake
  typedef struct packed {
    logic valid;
    logic has_data;
  } hrs_req_t;

endpackage

// *** logic/hrs_sequencer.sv ***
// Purpose: Reset and start-up sequencer of a four-port hub
// Assumes: rst is the hardware reset, synchronous, active high
// Notes: Oscillator and PLL are modelled as enables driven out
//
// Overview of operation
// - Reset disables ports, drops power enables
// - Reset disables transceivers, pairs undriven
// - Reset aborts transactions, keeps no state
// - Reset returns registers to zero defaults
// - Reset stops oscillator, PLL, LEDs
// - Operational 500 us after reset release
// - Then read EEPROM unless SMBus disabled
// - Strap mode: outputs inactive within 1.5 us
// - Strap mode: attach within 100 ms
// - Complete host requests within 5 ms
// - EEPROM load at most 99.5 ms
// - SMBus mode: attach within 100 ms; a self-powered SMBus load waits with no limit
// - Bus reset never forwarded downstream
// - Bus reset: address zero, unconfigured
// - Bus reset drops all four power enables
// - Bus reset empties translator buffers
// - Bus reset wakes a suspended device
// - Strap selects power enable polarity
// - Sample LED straps after reset release
`timescale 1ns/100ps
module hrs_sequencer #(
  parameter int unsigned RECOVERY_CYC = hrs_pkg::RECOVERY_CYC,
  parameter int unsigned ATTACH_CYC = hrs_pkg::ATTACH_CYC,
  parameter int unsigned EEPROM_MAX_CYC = hrs_pkg::EEPROM_MAX_CYC,
  parameter int unsigned SMBUS_MAX_CYC = hrs_pkg::SMBUS_MAX_CYC,
  parameter int unsigned REQUEST_CYC = hrs_pkg::REQUEST_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire hrs_pkg::hrs_cfg_t cfg_select,
  input wire logic smbus_disable,
  input wire logic self_powered,
  input wire hrs_pkg::hrs_strap_t strap_in,
  input wire logic eeprom_done,
  input wire logic smbus_load_done,
  input wire logic bus_reset,
  input wire logic suspend_req,
  input wire logic set_address,
  input wire logic [6:0] address_in,
  input wire logic set_configured,
  input wire logic [hrs_pkg::PORTS-1:0] port_power_on,
  input wire hrs_pkg::hrs_req_t host_req,
  input wire logic req_done,
  output logic oscillator_enable,
  output logic pll_enable,
  output logic phy_enable,
  output logic dp_oe,
  output logic led_enable,
  output logic outputs_inactive,
  output logic eeprom_read_start,
  output logic upstream_attach,
  output logic [hrs_pkg::PORTS-1:0] port_enable,
  output logic [hrs_pkg::PORTS-1:0] downstream_power_enable,
  output logic downstream_reset,
  output logic [6:0] device_address,
  output logic configured,
  output logic suspended,
  output logic transaction_translator_flush,
  output logic transaction_abort,
  output logic config_timeout,
  output logic req_ack,
  output logic req_timeout,
  output hrs_pkg::hrs_strap_t strap_latched
);

  // ----------------------------------------------------------------
  // State and counters
  // ----------------------------------------------------------------
  hrs_pkg::hrs_state_t state_reg;
  hrs_pkg::hrs_state_t state_next;
  logic [31:0] cnt_reg;
  logic [31:0] attach_cnt_reg;
  logic [31:0] req_cnt_reg;
  logic [3:0] inact_cnt_reg;
  logic strap_taken_reg;
  logic load_done;
  logic load_over;
  logic [hrs_pkg::PORTS-1:0] power_reg;
  logic req_busy_reg;

  assign load_done = (cfg_select == hrs_pkg::HRS_CFG_EEPROM) ? eeprom_done :
                     (cfg_select == hrs_pkg::HRS_CFG_SMBUS) ? smbus_load_done : 1'b1;

  // Load deadline; self-powered SMBus load has none
  always_comb begin
    load_over = 1'b0;
    if (cfg_select == hrs_pkg::HRS_CFG_EEPROM) begin
      load_over = (cnt_reg >= EEPROM_MAX_CYC - 1);
    end else if (cfg_select == hrs_pkg::HRS_CFG_SMBUS && !self_powered) begin
      load_over = (cnt_reg >= SMBUS_MAX_CYC - 1);
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      hrs_pkg::HRS_S_RECOVER: begin
        if (cnt_reg >= RECOVERY_CYC - 1) begin
          state_next = hrs_pkg::HRS_S_LOAD;
        end
      end
      hrs_pkg::HRS_S_LOAD: begin
        if (load_done || load_over) begin
          state_next = hrs_pkg::HRS_S_APPLY;
        end
      end
      hrs_pkg::HRS_S_APPLY: begin
        state_next = hrs_pkg::HRS_S_RUN;
      end
      hrs_pkg::HRS_S_RUN: begin
        state_next = hrs_pkg::HRS_S_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= hrs_pkg::HRS_S_RECOVER;
    end else begin
      state_reg <= state_next;
    end
  end

  // Interval counter from the internal clock
  always_ff @(posedge ref_clk) begin
    if (rst || state_next != state_reg) begin
      cnt_reg <= 32'h0000_0000;
    end else if (cnt_reg != 32'hffff_ffff) begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Reset-time pin state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      oscillator_enable <= 1'b0;
      pll_enable <= 1'b0;
      led_enable <= 1'b0;
      phy_enable <= 1'b0;
      dp_oe <= 1'b0;
    end else begin
      oscillator_enable <= 1'b1;
      pll_enable <= 1'b1;
      led_enable <= (state_reg == hrs_pkg::HRS_S_RUN);
      phy_enable <= (state_reg == hrs_pkg::HRS_S_RUN);
      dp_oe <= upstream_attach;
    end
  end

  // Outputs settle inactive well inside 1.5 us
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      inact_cnt_reg <= 4'h0;
      outputs_inactive <= 1'b0;
    end else if (inact_cnt_reg != 4'hf) begin
      inact_cnt_reg <= inact_cnt_reg + 4'h1;
      outputs_inactive <= (inact_cnt_reg >= 4'h1);
    end
  end

  // Straps caught on the first clock after release
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strap_taken_reg <= 1'b0;
      strap_latched <= '0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_latched <= strap_in;
    end
  end

  // EEPROM read starts when operational
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eeprom_read_start <= 1'b0;
    end else begin
      eeprom_read_start <= (state_reg == hrs_pkg::HRS_S_RECOVER) &&
                           (state_next == hrs_pkg::HRS_S_LOAD) &&
                           (cfg_select == hrs_pkg::HRS_CFG_EEPROM) && !smbus_disable;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      config_timeout <= 1'b0;
    end else if (state_reg == hrs_pkg::HRS_S_LOAD && load_over && !load_done) begin
      config_timeout <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Attach
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      upstream_attach <= 1'b0;
      attach_cnt_reg <= 32'h0000_0000;
    end else if (state_reg == hrs_pkg::HRS_S_RUN && !upstream_attach) begin
      // Attach soon after configuration, far inside 100 ms
      attach_cnt_reg <= attach_cnt_reg + 32'h0000_0001;
      if (attach_cnt_reg >= 32'h0000_0001 || attach_cnt_reg >= ATTACH_CYC - 1) begin
        upstream_attach <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // USB bus reset and device state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || bus_reset) begin
      device_address <= hrs_pkg::ADDR_RESET;
      configured <= 1'b0;
    end else begin
      if (set_address) begin
        device_address <= address_in;
      end
      if (set_configured) begin
        configured <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || bus_reset) begin
      suspended <= 1'b0;
    end else if (suspend_req) begin
      suspended <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      transaction_translator_flush <= 1'b1;
      transaction_abort <= 1'b1;
      downstream_reset <= 1'b0;
    end else begin
      transaction_translator_flush <= bus_reset;
      transaction_abort <= bus_reset;
      downstream_reset <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Per-port power
  // ----------------------------------------------------------------
  for (genvar p = 0; p < hrs_pkg::PORTS; p++) begin : g_port
    // Logical power, taken from the host once configured
    always_ff @(posedge ref_clk) begin
      if (rst || bus_reset) begin
        power_reg[p] <= 1'b0;
        port_enable[p] <= 1'b0;
      end else if (configured && state_reg == hrs_pkg::HRS_S_RUN) begin
        power_reg[p] <= port_power_on[p];
        port_enable[p] <= port_power_on[p];
      end
    end

    // Pin level follows the polarity strap
    // Off level from the raw strap in reset, so active-low ports stay unpowered
    always_ff @(posedge ref_clk) begin
      if (rst || !strap_taken_reg) begin
        downstream_power_enable[p] <= ~strap_in.power_enable_polarity_strap;
      end else if (strap_latched.power_enable_polarity_strap) begin
        downstream_power_enable[p] <= power_reg[p];
      end else begin
        downstream_power_enable[p] <= ~power_reg[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // Host request completion watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || bus_reset) begin
      req_busy_reg <= 1'b0;
      req_cnt_reg <= 32'h0000_0000;
      req_ack <= 1'b0;
      req_timeout <= 1'b0;
    end else begin
      req_ack <= 1'b0;
      req_timeout <= 1'b0;
      if (!req_busy_reg) begin
        if (host_req.valid) begin
          req_busy_reg <= 1'b1;
          req_cnt_reg <= 32'h0000_0000;
        end
      end else if (req_done) begin
        req_busy_reg <= 1'b0;
        req_ack <= 1'b1;
      end else if (req_cnt_reg >= REQUEST_CYC - 2) begin
        req_busy_reg <= 1'b0;
        req_ack <= 1'b1;
        req_timeout <= 1'b1;
      end else begin
        req_cnt_reg <= req_cnt_reg + 32'h0000_0001;
      end
    end
  end

endmodule // hrs_sequencer

// *** verification/hrs_host_model.sv ***
// Purpose: Host and configuration source beside the sequencer
// Assumes: delay of 2 or more cycles
// Notes: A request with respond low is never answered
`timescale 1ns/100ps
module hrs_host_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic eeprom_read_start,
  input wire logic load_go,
  input wire logic respond,
  input wire logic [7:0] delay,
  input wire hrs_pkg::hrs_req_t host_req,
  output logic eeprom_done = 1'b0,
  output logic smbus_load_done = 1'b0,
  output logic req_done = 1'b0
);
  logic [7:0] load_cnt = 8'h00;
  logic [7:0] req_cnt = 8'h00;
  logic from_smbus = 1'b0;
  always @(posedge ref_clk) begin
    eeprom_done <= 1'b0;
    smbus_load_done <= 1'b0;
    req_done <= 1'b0;
    if (rst) begin
      load_cnt <= 8'h00;
      req_cnt <= 8'h00;
    end else begin
      if (eeprom_read_start || load_go) begin
        load_cnt <= delay;
        from_smbus <= load_go;
      end else if (load_cnt != 8'h00) begin
        load_cnt <= load_cnt - 8'h01;
        eeprom_done <= load_cnt == 8'h01 && !from_smbus;
        smbus_load_done <= load_cnt == 8'h01 && from_smbus;
      end
      if (host_req.valid) begin
        req_cnt <= respond ? delay : 8'h00;
      end else if (req_cnt != 8'h00) begin
        req_cnt <= req_cnt - 8'h01;
        req_done <= req_cnt == 8'h01;
      end
    end
  end
endmodule // hrs_host_model

// *** verification/hrs_seq_checker.sv ***
// Purpose: Port checks for the hub reset sequencer
// Assumes: rst synchronous, active high
// Notes: Checks of reset itself are not disabled by rst
`timescale 1ns/100ps
module hrs_seq_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bus_reset,
  input wire hrs_pkg::hrs_strap_t strap_in,
  input wire logic oscillator_enable,
  input wire logic pll_enable,
  input wire logic phy_enable,
  input wire logic dp_oe,
  input wire logic led_enable,
  input wire logic outputs_inactive,
  input wire logic eeprom_read_start,
  input wire logic [hrs_pkg::PORTS-1:0] port_enable,
  input wire logic [hrs_pkg::PORTS-1:0] downstream_power_enable,
  input wire logic [6:0] device_address,
  input wire logic configured,
  input wire logic suspended,
  input wire logic transaction_translator_flush,
  input wire logic transaction_abort,
  input wire hrs_pkg::hrs_strap_t strap_latched
);
  localparam int INACT_MAX = 187;
  default clocking cb @(posedge ref_clk); endclocking
  sequence pins_idle_s;
    downstream_power_enable == {4{!strap_latched.power_enable_polarity_strap}};
  endsequence
  sequence cleared_s;
    device_address == 7'h00 && !configured && !suspended;
  endsequence
  power_off_a: assert property (rst |=> !port_enable &&
    downstream_power_enable == {4{!$past(strap_in.power_enable_polarity_strap)}})
    else $error("ports live in reset");
  phy_off_a: assert property (rst |=> !phy_enable && !dp_oe)
    else $error("transceiver live in reset");
  abort_reset_a: assert property (rst |=> transaction_abort && transaction_translator_flush)
    else $error("no abort in reset");
  regs_zero_a: assert property (rst |=> cleared_s)
    else $error("state kept over reset");
  clocks_off_a: assert property (rst |=> !oscillator_enable && !pll_enable && !led_enable)
    else $error("clock or led live in reset");
  inactive_time_a: assert property (disable iff (rst) $fell(rst) |-> ##[0:INACT_MAX] outputs_inactive)
    else $error("outputs not inactive in time");
  read_pulse_a: assert property (disable iff (rst) eeprom_read_start |=> !eeprom_read_start)
    else $error("read start longer than a cycle");
  bus_clear_a: assert property (disable iff (rst) bus_reset |=> cleared_s)
    else $error("bus reset left state");
  bus_power_a: assert property (disable iff (rst) bus_reset |=> ##1 pins_idle_s)
    else $error("power kept over bus reset");
  bus_flush_a: assert property (disable iff (rst) bus_reset |=> transaction_translator_flush)
    else $error("buffers not flushed");
endmodule // hrs_seq_checker
bind hrs_sequencer hrs_seq_checker u_hrs_seq_checker (.ref_clk(ref_clk), .rst(rst),
  .bus_reset(bus_reset), .strap_in(strap_in),
  .oscillator_enable(oscillator_enable), .pll_enable(pll_enable),
  .phy_enable(phy_enable), .dp_oe(dp_oe), .led_enable(led_enable),
  .outputs_inactive(outputs_inactive), .eeprom_read_start(eeprom_read_start),
  .port_enable(port_enable), .downstream_power_enable(downstream_power_enable),
  .device_address(device_address), .configured(configured), .suspended(suspended),
  .transaction_translator_flush(transaction_translator_flush),
  .transaction_abort(transaction_abort), .strap_latched(strap_latched));

// *** verification/hub_reset_sequencer_test.sv ***
// Purpose: Self-checking bench for the hub reset sequencer
// Assumes: Shortened counts at the instance
// Notes: Six cases over the four configuration sources, two each for EEPROM and SMBus
`timescale 1ns/100ps
module hub_reset_sequencer_test;
  localparam int R = 20;
  localparam int E = 60;
  localparam int A = 40;
  localparam int Q = 50;
  localparam hrs_pkg::hrs_cfg_t CFG [6] = '{hrs_pkg::HRS_CFG_EEPROM, hrs_pkg::HRS_CFG_STRAP,
    hrs_pkg::HRS_CFG_SMBUS, hrs_pkg::HRS_CFG_SMBUS, hrs_pkg::HRS_CFG_EEPROM,
    hrs_pkg::HRS_CFG_DEFAULT};
  localparam logic [5:0] DIS = 6'h10;
  localparam logic [5:0] SELFP = 6'h08;
  localparam logic [5:0] TMO = 6'h14;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  hrs_pkg::hrs_cfg_t cfg_select = hrs_pkg::HRS_CFG_STRAP;
  logic smbus_disable = 1'b0, self_powered = 1'b0, bus_reset = 1'b0, suspend_req = 1'b0;
  logic set_address = 1'b0, set_configured = 1'b0, load_go = 1'b0, respond = 1'b0;
  hrs_pkg::hrs_strap_t strap_in = 3'h0;
  hrs_pkg::hrs_strap_t strap_latched;
  hrs_pkg::hrs_req_t host_req = 2'h0;
  logic [6:0] address_in = 7'h00;
  logic [6:0] device_address;
  logic [3:0] port_power_on = 4'h0;
  logic [3:0] port_enable, downstream_power_enable;
  logic [7:0] delay = 8'h04;
  logic eeprom_done, smbus_load_done, req_done, eeprom_read_start, upstream_attach;
  logic downstream_reset, configured, suspended, flush, config_timeout, req_ack, req_timeout;
  logic [31:0] seed = 32'hba69;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  hrs_sequencer #(.RECOVERY_CYC(R), .ATTACH_CYC(A), .EEPROM_MAX_CYC(E), .SMBUS_MAX_CYC(E),
    .REQUEST_CYC(Q)) u_hrs_sequencer (.ref_clk(ref_clk), .rst(rst), .cfg_select(cfg_select),
    .smbus_disable(smbus_disable), .self_powered(self_powered), .strap_in(strap_in),
    .eeprom_done(eeprom_done), .smbus_load_done(smbus_load_done), .bus_reset(bus_reset),
    .suspend_req(suspend_req), .set_address(set_address), .address_in(address_in),
    .set_configured(set_configured), .port_power_on(port_power_on), .host_req(host_req),
    .req_done(req_done), .oscillator_enable(), .pll_enable(), .phy_enable(), .dp_oe(),
    .led_enable(), .outputs_inactive(), .eeprom_read_start(eeprom_read_start),
    .upstream_attach(upstream_attach), .port_enable(port_enable),
    .downstream_power_enable(downstream_power_enable), .downstream_reset(downstream_reset),
    .device_address(device_address), .configured(configured), .suspended(suspended),
    .transaction_translator_flush(flush), .transaction_abort(),
    .config_timeout(config_timeout), .req_ack(req_ack), .req_timeout(req_timeout),
    .strap_latched(strap_latched));
  hrs_host_model u_hrs_host_model (.ref_clk(ref_clk), .rst(rst),
    .eeprom_read_start(eeprom_read_start), .load_go(load_go), .respond(respond),
    .delay(delay), .host_req(host_req), .eeprom_done(eeprom_done),
    .smbus_load_done(smbus_load_done), .req_done(req_done));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] pins(input logic pol, input logic [3:0] on);
    return pol ? on : ~on;
  endfunction
  function automatic logic sig(input int k);
    case (k)
      0: return eeprom_read_start;
      1: return upstream_attach;
      2: return req_ack;
      default: return req_timeout;
    endcase
  endfunction
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_hi(input int k, input int lim, output int n);
    n = 0;
    while (sig(k) !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    hrs_pkg::hrs_strap_t s;
    logic [31:0] r;
    int n;
    repeat (3) @(posedge ref_clk);
    for (int t = 0; t < 6; t++) begin
      r = rnd();
      s = r[2:0];
      rst <= 1'b1;
      cfg_select <= CFG[t];
      smbus_disable <= DIS[t];
      self_powered <= SELFP[t];
      strap_in <= s;
      delay <= {4'h0, r[7:4]} + 8'h02;
      repeat (125) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(negedge ref_clk);
      check("strap_latched", strap_latched, s);
      check("idle_power", downstream_power_enable, pins(s[2], 4'h0));
      check("port_enable", port_enable, 8'h00);
      wait_hi(0, R + E, n);
      check("read_start", n >= R - 2 && n <= R + 2, CFG[t] == 2'h1 && !DIS[t]);
      if (SELFP[t]) begin
        repeat (E + A) @(negedge ref_clk);
        check("early_attach", upstream_attach, 8'h00);
        check("self_timeout", config_timeout, 8'h00);
        @(posedge ref_clk);
        load_go <= 1'b1;
        @(posedge ref_clk);
        load_go <= 1'b0;
      end
      wait_hi(1, E + A + 20, n);
      check("attach", upstream_attach, 8'h01);
      check("timeout", config_timeout, TMO[t]);
      @(posedge ref_clk);
      set_address <= 1'b1;
      set_configured <= 1'b1;
      address_in <= r[14:8] | 7'h01;
      @(posedge ref_clk);
      set_address <= 1'b0;
      set_configured <= 1'b0;
      port_power_on <= r[19:16] | 4'h1;
      repeat (4) @(negedge ref_clk);
      check("address", {1'b0, device_address}, {1'b0, r[14:8] | 7'h01});
      check("power_on", downstream_power_enable, pins(s[2], r[19:16] | 4'h1));
      for (int k = 0; k < 2; k++) begin
        @(posedge ref_clk);
        respond <= k == 0;
        host_req <= {1'b1, r[20 + k]};
        @(posedge ref_clk);
        host_req <= 2'h0;
        wait_hi(2 + k, Q + 5, n);
        check("request_end", sig(2 + k), 8'h01);
        check("req_timeout", req_timeout, k == 1);
      end
      @(posedge ref_clk);
      suspend_req <= 1'b1;
      @(posedge ref_clk);
      suspend_req <= 1'b0;
      repeat (A) @(posedge ref_clk);
      bus_reset <= 1'b1;
      check("suspend", suspended, 8'h01);
      repeat (3) @(negedge ref_clk);
      check("bus_address", {1'b0, device_address}, 8'h00);
      check("bus_state", {6'h00, configured, suspended}, 8'h00);
      check("bus_power", downstream_power_enable, pins(s[2], 4'h0));
      check("flush", {flush, downstream_reset}, 8'h02);
      @(posedge ref_clk);
      bus_reset <= 1'b0;
      $display("test %0d done", t);
    end
    end_of_test();
  end
endmodule // hub_reset_sequencer_test
